// *** bus_stat_regs.vh ***
// register map, field positions and reset values of the bus statistics monitor
// How it works
// (RULE_01) software pulses stat_clear before each run
// (RULE_02) configure everything while stat_run_enable is low
// (RULE_03) enable only after a frame end is seen
// (RULE_04) latency uses only latency_target_id reads
// (RULE_05) keep largest latency of selected ID
// (RULE_06) count cycles while a run is active
// (RULE_07) accumulate qualifying latencies and count samples
// (RULE_08) only latencies above threshold are sampled
// (RULE_09) frame_mode 1 stops at frame end
// (RULE_10) total read bytes, one ID or all
// (RULE_11) total write bytes, one ID or all
// (RULE_12) real or memory aligned byte totals
// (RULE_13) wrap bursts count as already aligned
// (RULE_14) detect reads inside read window
// (RULE_15) detect writes inside write window
// (RULE_16) watch filter: one ID under mask, or all
// (RULE_17) window hit sets flags and interrupt
// (RULE_18) record IDs that caused read/write hits
// (RULE_19) clear zeroes all counters, flags, records
// (RULE_20) latency from address accept to last beat
`ifndef BUS_STAT_REGS_VH
`define BUS_STAT_REGS_VH

// ==========================================================================
// register byte offsets
`define REG_CTRL        6'h00
`define REG_LAT_CFG     6'h04
`define REG_ID_CFG      6'h08
`define REG_RWIN_LOW    6'h0c
`define REG_RWIN_HIGH   6'h10
`define REG_WWIN_LOW    6'h14
`define REG_WWIN_HIGH   6'h18
`define REG_EVENT       6'h1c
`define REG_WORK_CNT    6'h20
`define REG_MAX_LAT     6'h24
`define REG_SAMP_NUM    6'h28
`define REG_ACC_SUM     6'h2c
`define REG_RD_BYTES    6'h30
`define REG_WR_BYTES    6'h34

// ==========================================================================
// control register fields
`define CTRL_CLEAR      0
`define CTRL_RUN        1
`define CTRL_FRAME      2
`define CTRL_STYLE      3
`define CTRL_WRAPC      4
`define CTRL_ALIGN_LO   5
`define CTRL_ALIGN_HI   6
`define CTRL_RDSEL      7
`define CTRL_WRSEL      8
`define CTRL_WATCHSEL   9
`define CTRL_W          10

// id configuration fields
`define IDC_RD_LO       0
`define IDC_WR_LO       8
`define IDC_WATCH_LO    16
`define IDC_MASK_LO     24
// latency configuration fields
`define LAT_ID_LO       0
`define LAT_THR_LO      16
// event register fields
`define EV_RD_HIT       0
`define EV_WR_HIT       1
`define EV_FINISH       2
`define EV_RD_ID_LO     8
`define EV_WR_ID_LO     16

// ==========================================================================
// constants
`define RST_ZERO32      32'h0000_0000
`define RST_CTRL        10'h000
`define ALIGN_BASE      3'h4
`define BURST_WRAP      2'h2
`define ONE32           32'h0000_0001

`endif

// *** chan_probe.v ***
// address channel probe: byte count, count filter and window watch
`default_nettype none
`include "bus_stat_regs.vh"

module chan_probe #(
	parameter IDW = 7
) (
	input  wire [31:0]    i_addr,
	input  wire [7:0]     i_len,
	input  wire [2:0]     i_size,
	input  wire [1:0]     i_burst,
	input  wire [IDW-1:0] i_id,
	input  wire           i_style,
	input  wire [1:0]     i_align,
	input  wire           i_wrapc,
	input  wire           i_cnt_sel,
	input  wire [IDW-1:0] i_cnt_id,
	input  wire [31:0]    i_win_low,
	input  wire [31:0]    i_win_high,
	input  wire           i_watch_sel,
	input  wire [IDW-1:0] i_watch_id,
	input  wire [IDW-1:0] i_watch_mask,
	output reg  [31:0]    o_bytes,
	output wire           o_count_ok,
	output wire           o_hit
);
	wire [31:0] real_bytes;
	wire [31:0] gran_mask;
	wire [31:0] lo_edge;
	wire [31:0] hi_edge;
	wire [2:0]  gshift;
	wire        id_watch;

	// real bytes of the burst: beats times beat size
	assign real_bytes = ({24'h000000, i_len} + `ONE32) << i_size;
	// granule is 16 bytes times two to the align kind
	assign gshift     = `ALIGN_BASE + {1'b0, i_align};
	assign gran_mask  = (`ONE32 << gshift) - `ONE32;
	assign lo_edge    = i_addr & ~gran_mask;
	assign hi_edge    = (i_addr + real_bytes + gran_mask) & ~gran_mask;

	// pick real or aligned total
	always @* begin
		o_bytes = real_bytes; // RULE_12
		if (i_style && !(i_wrapc && i_burst == `BURST_WRAP)) begin // RULE_13
			o_bytes = hi_edge - lo_edge; // RULE_12
		end
	end

	assign o_count_ok = !i_cnt_sel || (i_id == i_cnt_id); // RULE_10 RULE_11
	// masked bits of the id are ignored when one id is watched
	assign id_watch   = !i_watch_sel ||
		(((i_id ^ i_watch_id) & ~i_watch_mask) == {IDW{1'b0}}); // RULE_16
	assign o_hit      = id_watch && (i_addr >= i_win_low) &&
		(i_addr < i_win_high); // RULE_14 RULE_15
endmodule // chan_probe

`default_nettype wire

// *** bus_stat_mon.v ***
// bus traffic statistics monitor with apb register slave
`default_nettype none
`include "bus_stat_regs.vh"

module bus_stat_mon #(
	parameter IDW      = 7,
	parameter THRW     = 16,
	parameter LAT_AW   = 3
) (
	input  wire           i_mclk,
	input  wire           i_nrst,
	// apb slave
	input  wire           i_psel,
	input  wire           i_penable,
	input  wire           i_pwrite,
	input  wire [5:0]     i_paddr,
	input  wire [31:0]    i_pwdata,
	input  wire [3:0]     i_pstrb,
	output reg            o_pready,
	output reg  [31:0]    o_prdata,
	output reg            o_pslverr,
	// observed read address channel
	input  wire           i_arvalid,
	input  wire           i_arready,
	input  wire [IDW-1:0] i_arid,
	input  wire [31:0]    i_araddr,
	input  wire [7:0]     i_arlen,
	input  wire [2:0]     i_arsize,
	input  wire [1:0]     i_arburst,
	// observed read data channel
	input  wire           i_rvalid,
	input  wire           i_rready,
	input  wire [IDW-1:0] i_rid,
	input  wire           i_rlast,
	// observed write address channel
	input  wire           i_awvalid,
	input  wire           i_awready,
	input  wire [IDW-1:0] i_awid,
	input  wire [31:0]    i_awaddr,
	input  wire [7:0]     i_awlen,
	input  wire [2:0]     i_awsize,
	input  wire [1:0]     i_awburst,
	// frame boundary and interrupt
	input  wire           i_frame_end,
	output reg            o_irq
);
	localparam LAT_DEPTH = 1 << LAT_AW;

	// ======================================================================
	// reset release through two flops
	reg rst_s1_q;
	reg rst_n_q;
	always @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	// ======================================================================
	// configuration registers
	reg  [`CTRL_W-1:0] ctrl_q;
	reg  [31:0]        lat_cfg_q;
	reg  [31:0]        id_cfg_q;
	reg  [31:0]        rwin_low_q;
	reg  [31:0]        rwin_high_q;
	reg  [31:0]        wwin_low_q;
	reg  [31:0]        wwin_high_q;

	wire            stat_clear    = ctrl_q[`CTRL_CLEAR];
	wire            stat_run_enable = ctrl_q[`CTRL_RUN];
	wire            frame_mode    = ctrl_q[`CTRL_FRAME];
	wire            byte_count_style = ctrl_q[`CTRL_STYLE];
	wire            wrap_align_correction = ctrl_q[`CTRL_WRAPC];
	wire [1:0]      memory_align_kind = ctrl_q[`CTRL_ALIGN_HI:`CTRL_ALIGN_LO];
	wire            read_id_filter_select  = ctrl_q[`CTRL_RDSEL];
	wire            write_id_filter_select = ctrl_q[`CTRL_WRSEL];
	wire            watch_id_filter_select = ctrl_q[`CTRL_WATCHSEL];
	wire [IDW-1:0]  latency_target_id = lat_cfg_q[`LAT_ID_LO +: IDW];
	wire [THRW-1:0] latency_threshold = lat_cfg_q[`LAT_THR_LO +: THRW];
	wire [IDW-1:0]  read_count_id  = id_cfg_q[`IDC_RD_LO +: IDW];
	wire [IDW-1:0]  write_count_id = id_cfg_q[`IDC_WR_LO +: IDW];
	wire [IDW-1:0]  watch_id       = id_cfg_q[`IDC_WATCH_LO +: IDW];
	wire [IDW-1:0]  watch_id_mask  = id_cfg_q[`IDC_MASK_LO +: IDW];

	// ======================================================================
	// statistics state
	reg  [31:0]    work_cnt_q;
	reg  [31:0]    max_lat_q;
	reg  [31:0]    samp_num_q;
	reg  [31:0]    acc_sum_q;
	reg  [31:0]    rd_bytes_q;
	reg  [31:0]    wr_bytes_q;
	reg            finished_q;
	reg            read_window_hit_q;
	reg            write_window_hit_q;
	reg  [IDW-1:0] read_hit_id_record_q;
	reg  [IDW-1:0] write_hit_id_record_q;
	reg  [31:0]    tick_q;
	reg  [31:0]    stamp_mem [0:LAT_DEPTH-1];
	reg  [LAT_AW:0] wr_ptr_q;
	reg  [LAT_AW:0] rd_ptr_q;

	// ======================================================================
	// apb access decode
	wire apb_acc = i_psel && i_penable && !o_pready;
	// a write lands at the edge where the master samples ready high
	wire apb_wr  = i_psel && i_penable && o_pready && i_pwrite;
	reg  [31:0] rd_mux;
	reg         addr_ok;
	wire [31:0] event_flags;

	assign event_flags = {{(16-IDW){1'b0}}, write_hit_id_record_q,
		1'b0, read_hit_id_record_q, 5'h00, finished_q,
		write_window_hit_q, read_window_hit_q}; // RULE_17 RULE_18

	// read mux, unmapped reads give zero with slave error
	always @* begin
		rd_mux  = `RST_ZERO32;
		addr_ok = 1'b1;
		case (i_paddr)
		`REG_CTRL:      rd_mux = {{(32-`CTRL_W){1'b0}}, ctrl_q};
		`REG_LAT_CFG:   rd_mux = lat_cfg_q;
		`REG_ID_CFG:    rd_mux = id_cfg_q;
		`REG_RWIN_LOW:  rd_mux = rwin_low_q;
		`REG_RWIN_HIGH: rd_mux = rwin_high_q;
		`REG_WWIN_LOW:  rd_mux = wwin_low_q;
		`REG_WWIN_HIGH: rd_mux = wwin_high_q;
		`REG_EVENT:     rd_mux = event_flags;
		`REG_WORK_CNT:  rd_mux = work_cnt_q;
		`REG_MAX_LAT:   rd_mux = max_lat_q;
		`REG_SAMP_NUM:  rd_mux = samp_num_q;
		`REG_ACC_SUM:   rd_mux = acc_sum_q;
		`REG_RD_BYTES:  rd_mux = rd_bytes_q;
		`REG_WR_BYTES:  rd_mux = wr_bytes_q;
		default:        addr_ok = 1'b0;
		endcase
	end

	// byte lane merge for writable words
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  strb;
		integer k;
		begin
			merge = old;
			for (k = 0; k < 4; k = k + 1) begin
				if (strb[k]) begin
					merge[k*8 +: 8] = nw[k*8 +: 8];
				end
			end
		end
	endfunction

	wire [31:0] ctrl_wide = {{(32-`CTRL_W){1'b0}}, ctrl_q};
	wire [31:0] ctrl_new  = merge(ctrl_wide, i_pwdata, i_pstrb);

	// apb answer one cycle into the access phase
	always @(posedge i_mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			o_pready  <= 1'b0;
			o_prdata  <= `RST_ZERO32;
			o_pslverr <= 1'b0;
		end else begin
			o_pready  <= apb_acc;
			o_prdata  <= (apb_acc && !i_pwrite) ? rd_mux : `RST_ZERO32;
			o_pslverr <= apb_acc && !addr_ok;
		end
	end

	// configuration writes
	always @(posedge i_mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ctrl_q      <= `RST_CTRL;
			lat_cfg_q   <= `RST_ZERO32;
			id_cfg_q    <= `RST_ZERO32;
			rwin_low_q  <= `RST_ZERO32;
			rwin_high_q <= `RST_ZERO32;
			wwin_low_q  <= `RST_ZERO32;
			wwin_high_q <= `RST_ZERO32;
		end else if (apb_wr) begin
			case (i_paddr)
			`REG_CTRL:      ctrl_q <= ctrl_new[`CTRL_W-1:0];
			`REG_LAT_CFG:   lat_cfg_q <= merge(lat_cfg_q, i_pwdata, i_pstrb);
			`REG_ID_CFG:    id_cfg_q <= merge(id_cfg_q, i_pwdata, i_pstrb);
			`REG_RWIN_LOW:  rwin_low_q <= merge(rwin_low_q, i_pwdata, i_pstrb);
			`REG_RWIN_HIGH: rwin_high_q <= merge(rwin_high_q, i_pwdata,
				i_pstrb);
			`REG_WWIN_LOW:  wwin_low_q <= merge(wwin_low_q, i_pwdata, i_pstrb);
			`REG_WWIN_HIGH: wwin_high_q <= merge(wwin_high_q, i_pwdata,
				i_pstrb);
			default:        ctrl_q <= ctrl_q;
			endcase
		end
	end

	// ======================================================================
	// channel probes
	wire [31:0] ar_bytes;
	wire [31:0] aw_bytes;
	wire        ar_cnt_ok;
	wire        aw_cnt_ok;
	wire        ar_hit;
	wire        aw_hit;

	chan_probe #(.IDW(IDW)) u_ar_probe (
		.i_addr       (i_araddr),
		.i_len        (i_arlen),
		.i_size       (i_arsize),
		.i_burst      (i_arburst),
		.i_id         (i_arid),
		.i_style      (byte_count_style),
		.i_align      (memory_align_kind),
		.i_wrapc      (wrap_align_correction),
		.i_cnt_sel    (read_id_filter_select),
		.i_cnt_id     (read_count_id),
		.i_win_low    (rwin_low_q),
		.i_win_high   (rwin_high_q),
		.i_watch_sel  (watch_id_filter_select),
		.i_watch_id   (watch_id),
		.i_watch_mask (watch_id_mask),
		.o_bytes      (ar_bytes),
		.o_count_ok   (ar_cnt_ok),
		.o_hit        (ar_hit)
	);

	chan_probe #(.IDW(IDW)) u_aw_probe (
		.i_addr       (i_awaddr),
		.i_len        (i_awlen),
		.i_size       (i_awsize),
		.i_burst      (i_awburst),
		.i_id         (i_awid),
		.i_style      (byte_count_style),
		.i_align      (memory_align_kind),
		.i_wrapc      (wrap_align_correction),
		.i_cnt_sel    (write_id_filter_select),
		.i_cnt_id     (write_count_id),
		.i_win_low    (wwin_low_q),
		.i_win_high   (wwin_high_q),
		.i_watch_sel  (watch_id_filter_select),
		.i_watch_id   (watch_id),
		.i_watch_mask (watch_id_mask),
		.o_bytes      (aw_bytes),
		.o_count_ok   (aw_cnt_ok),
		.o_hit        (aw_hit)
	);

	// ======================================================================
	// run control and latency timing
	wire run_active = stat_run_enable && !finished_q;
	wire ar_fire    = i_arvalid && i_arready;
	wire aw_fire    = i_awvalid && i_awready;
	wire ar_target  = ar_fire && (i_arid == latency_target_id); // RULE_04
	wire r_target   = i_rvalid && i_rready && i_rlast &&
		(i_rid == latency_target_id); // RULE_04
	wire lat_full   = (wr_ptr_q[LAT_AW] != rd_ptr_q[LAT_AW]) &&
		(wr_ptr_q[LAT_AW-1:0] == rd_ptr_q[LAT_AW-1:0]);
	wire lat_empty  = (wr_ptr_q == rd_ptr_q);
	wire lat_push   = ar_target && !lat_full;
	wire lat_pop    = r_target && !lat_empty;
	wire [31:0] lat_now = tick_q - stamp_mem[rd_ptr_q[LAT_AW-1:0]]; // RULE_20
	wire lat_sample = lat_pop && run_active &&
		(lat_now > {{(32-THRW){1'b0}}, latency_threshold}); // RULE_08

	// free running timestamp for address acceptance
	always @(posedge i_mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			tick_q <= `RST_ZERO32;
		end else begin
			tick_q <= tick_q + `ONE32;
		end
	end

	// same-id reads return in order, so one stamp queue suffices
	always @(posedge i_mclk) begin
		if (lat_push) begin
			stamp_mem[wr_ptr_q[LAT_AW-1:0]] <= tick_q; // RULE_20
		end
	end

	// stamp queue pointers
	always @(posedge i_mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			wr_ptr_q <= {(LAT_AW+1){1'b0}};
			rd_ptr_q <= {(LAT_AW+1){1'b0}};
		end else if (stat_clear) begin
			wr_ptr_q <= {(LAT_AW+1){1'b0}}; // RULE_19
			rd_ptr_q <= {(LAT_AW+1){1'b0}};
		end else begin
			if (lat_push) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (lat_pop) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
		end
	end

	// ======================================================================
	// counters and event capture
	always @(posedge i_mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			work_cnt_q            <= `RST_ZERO32;
			max_lat_q             <= `RST_ZERO32;
			samp_num_q            <= `RST_ZERO32;
			acc_sum_q             <= `RST_ZERO32;
			rd_bytes_q            <= `RST_ZERO32;
			wr_bytes_q            <= `RST_ZERO32;
			finished_q            <= 1'b0;
			read_window_hit_q     <= 1'b0;
			write_window_hit_q    <= 1'b0;
			read_hit_id_record_q  <= {IDW{1'b0}};
			write_hit_id_record_q <= {IDW{1'b0}};
		end else if (stat_clear) begin
			work_cnt_q            <= `RST_ZERO32; // RULE_19
			max_lat_q             <= `RST_ZERO32;
			samp_num_q            <= `RST_ZERO32;
			acc_sum_q             <= `RST_ZERO32;
			rd_bytes_q            <= `RST_ZERO32;
			wr_bytes_q            <= `RST_ZERO32;
			finished_q            <= 1'b0;
			read_window_hit_q     <= 1'b0;
			write_window_hit_q    <= 1'b0;
			read_hit_id_record_q  <= {IDW{1'b0}};
			write_hit_id_record_q <= {IDW{1'b0}};
		end else if (run_active) begin
			work_cnt_q <= work_cnt_q + `ONE32; // RULE_06
			if (lat_pop && lat_now > max_lat_q) begin
				max_lat_q <= lat_now; // RULE_05
			end
			if (lat_sample) begin
				samp_num_q <= samp_num_q + `ONE32; // RULE_07
				acc_sum_q  <= acc_sum_q + lat_now; // RULE_07
			end
			if (ar_fire && ar_cnt_ok) begin
				rd_bytes_q <= rd_bytes_q + ar_bytes; // RULE_10
			end
			if (aw_fire && aw_cnt_ok) begin
				wr_bytes_q <= wr_bytes_q + aw_bytes; // RULE_11
			end
			if (ar_fire && ar_hit) begin
				read_window_hit_q    <= 1'b1; // RULE_17
				read_hit_id_record_q <= i_arid; // RULE_18
			end
			if (aw_fire && aw_hit) begin
				write_window_hit_q    <= 1'b1; // RULE_17
				write_hit_id_record_q <= i_awid; // RULE_18
			end
			if (frame_mode && i_frame_end) begin
				finished_q <= 1'b1; // RULE_09
			end
		end
	end

	// interrupt follows any sticky event one cycle later
	always @(posedge i_mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= !stat_clear && (read_window_hit_q ||
				write_window_hit_q || finished_q); // RULE_17 RULE_09
		end
	end
endmodule // bus_stat_mon

`default_nettype wire

// *** bus_stat_mon_asserts.sv ***
// concurrent checks on the ports of the bus statistics monitor
`default_nettype none
`include "bus_stat_regs.vh"
module bus_stat_mon_asserts (
	input wire logic        i_mclk,
	input wire logic        i_nrst,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [5:0]  i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0]  i_pstrb,
	input wire logic        o_pready,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pslverr,
	input wire logic        i_arvalid,
	input wire logic        i_arready,
	input wire logic        i_awvalid,
	input wire logic        i_awready,
	input wire logic        i_frame_end,
	input wire logic        o_irq
);
timeunit 1ns;
timeprecision 1ps;
default clocking @(posedge i_mclk); endclocking
default disable iff (!i_nrst);
// ==========================================================================
// helpers
wire ctrl_wr = i_psel & i_penable & o_pready & i_pwrite & i_pstrb[0]
	& (i_paddr == `REG_CTRL);
wire cause = (i_arvalid & i_arready) | (i_awvalid & i_awready) | i_frame_end;
logic clr_q;
// clear bit as last written
always_ff @(posedge i_mclk or negedge i_nrst) begin
	if (!i_nrst) clr_q <= 1'b0;
	else if (ctrl_wr) clr_q <= i_pwdata[0];
end
sequence s_access;
	i_psel && i_penable && !o_pready;
endsequence
sequence s_clr;
	ctrl_wr && i_pwdata[0];
endsequence
// ==========================================================================
// assertions
a_one_wait: assert property (s_access |=> o_pready)
	else $error("ready not one cycle after access");
a_ready_pulse: assert property (o_pready |=> !o_pready)
	else $error("ready longer than one cycle");
a_ready_in_access: assert property (o_pready |-> i_psel && i_penable)
	else $error("ready outside access phase");
a_prdata_idle: assert property (!o_pready |-> o_prdata == 32'h0)
	else $error("read data not zero while idle");
a_err_unmapped: assert property (o_pready |->
	o_pslverr == (i_paddr > 6'h34 || i_paddr[1:0] != 2'b00))
	else $error("error flag does not match address");
a_clear_kills_irq: assert property (s_clr |-> ##[1:4] !o_irq)
	else $error("interrupt survives clear");
a_irq_has_cause: assert property ($rose(o_irq) |->
	$past(cause, 1) || $past(cause, 2) || $past(cause, 3))
	else $error("interrupt without bus event");
a_irq_drops_clear: assert property ($fell(o_irq) |->
	clr_q || $past(clr_q, 1) || $past(clr_q, 2))
	else $error("interrupt fell without clear");
endmodule // bus_stat_mon_asserts
bind bus_stat_mon bus_stat_mon_asserts u_bus_stat_mon_asserts (.i_mclk,
	.i_nrst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb,
	.o_pready, .o_prdata, .o_pslverr, .i_arvalid, .i_arready, .i_awvalid,
	.i_awready, .i_frame_end, .o_irq);
`default_nettype wire

// *** axi_obs_model.sv ***
// model of the observed bus: master and interconnect handshakes
`default_nettype none
module axi_obs_model (
	input  wire logic  i_mclk,
	output logic       o_arvalid,
	output logic       o_arready,
	output logic [6:0] o_arid,
	output logic [31:0] o_araddr,
	output logic [7:0] o_arlen,
	output logic [2:0] o_arsize,
	output logic [1:0] o_arburst,
	output logic       o_rvalid,
	output logic       o_rready,
	output logic [6:0] o_rid,
	output logic       o_rlast,
	output logic       o_awvalid,
	output logic       o_awready,
	output logic [6:0] o_awid,
	output logic [31:0] o_awaddr,
	output logic [7:0] o_awlen,
	output logic [2:0] o_awsize,
	output logic [1:0] o_awburst
);
timeunit 1ns;
timeprecision 1ps;
// idle channels at time zero
initial begin
	{o_arvalid, o_arready, o_arid, o_araddr, o_arlen, o_arsize} = '0;
	{o_arburst, o_rvalid, o_rready, o_rid, o_rlast} = '0;
	{o_awvalid, o_awready, o_awid, o_awaddr, o_awlen, o_awsize} = '0;
	o_awburst = '0;
end
// read: slow address ready, last beat lat cycles after acceptance
task rd(input logic [6:0] id, input logic [31:0] a, input logic [7:0] n,
	input logic [2:0] s, input logic [1:0] b, input int lat);
	@(posedge i_mclk);
	{o_arvalid, o_arid, o_araddr, o_arlen, o_arsize, o_arburst} <=
		{1'b1, id, a, n, s, b};
	@(posedge i_mclk);
	o_arready <= 1'b1;
	@(posedge i_mclk);
	// released lines show the inverse of the last value
	{o_arvalid, o_arready, o_arid, o_araddr} <= {2'b00, ~id, ~a};
	repeat (lat - 1) @(posedge i_mclk);
	{o_rvalid, o_rready, o_rlast, o_rid} <= {3'b111, id};
	@(posedge i_mclk);
	{o_rvalid, o_rready, o_rlast, o_rid} <= {3'b000, ~id};
endtask
// write address: prompt ready
task wr(input logic [6:0] id, input logic [31:0] a, input logic [7:0] n,
	input logic [2:0] s, input logic [1:0] b);
	@(posedge i_mclk);
	{o_awvalid, o_awready, o_awid, o_awaddr, o_awlen, o_awsize, o_awburst} <=
		{2'b11, id, a, n, s, b};
	@(posedge i_mclk);
	{o_awvalid, o_awready, o_awid, o_awaddr} <= {2'b00, ~id, ~a};
endtask
endmodule // axi_obs_model
`default_nettype wire

// *** test_bus_stat_mon.sv ***
// self-checking bench of the bus statistics monitor
`default_nettype none
`include "bus_stat_regs.vh"
module test_bus_stat_mon;
timeunit 1ns;
timeprecision 1ps;
logic        mclk, nrst, psel, penable, pwrite, frame_end, err_q;
logic [5:0]  paddr;
logic [31:0] pwdata, q;
wire         pready, pslverr, irq, arvalid, arready, rvalid, rready, rlast;
wire         awvalid, awready;
wire [31:0]  prdata, araddr, awaddr;
wire [6:0]   arid, rid, awid;
wire [7:0]   arlen, awlen;
wire [2:0]   arsize, awsize;
wire [1:0]   arburst, awburst;
int          num_errors, checks_done;
bus_stat_mon u_bus_stat_mon (
	.i_mclk(mclk), .i_nrst(nrst), .i_psel(psel), .i_penable(penable),
	.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hf),
	.o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
	.i_arvalid(arvalid), .i_arready(arready), .i_arid(arid),
	.i_araddr(araddr), .i_arlen(arlen), .i_arsize(arsize),
	.i_arburst(arburst), .i_rvalid(rvalid), .i_rready(rready), .i_rid(rid),
	.i_rlast(rlast), .i_awvalid(awvalid), .i_awready(awready), .i_awid(awid),
	.i_awaddr(awaddr), .i_awlen(awlen), .i_awsize(awsize),
	.i_awburst(awburst), .i_frame_end(frame_end), .o_irq(irq));
axi_obs_model u_axi_obs_model (
	.i_mclk(mclk), .o_arvalid(arvalid), .o_arready(arready), .o_arid(arid),
	.o_araddr(araddr), .o_arlen(arlen), .o_arsize(arsize), .o_arburst(arburst),
	.o_rvalid(rvalid), .o_rready(rready), .o_rid(rid), .o_rlast(rlast),
	.o_awvalid(awvalid), .o_awready(awready), .o_awid(awid),
	.o_awaddr(awaddr), .o_awlen(awlen), .o_awsize(awsize),
	.o_awburst(awburst));
initial begin
	mclk = 1'b0;
	forever #2.5 mclk = ~mclk;
end
// ==========================================================================
// shared tasks
task check(input logic [31:0] seen, input logic [31:0] exp);
	checks_done++;
	if (seen !== exp) begin
		num_errors++;
		$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
	end
endtask
task apb(input logic w, input logic [5:0] a, input logic [31:0] d);
	@(posedge mclk);
	{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
	@(posedge mclk);
	penable <= 1'b1;
	// only the watchdog ends a wait for ready
	do begin
		@(posedge mclk);
	end while (pready !== 1'b1);
	q = prdata;
	err_q = pslverr;
	{psel, penable} <= 2'b00;
endtask
task rchk(input logic [5:0] a, input logic [31:0] exp);
	apb(1'b0, a, 32'h0);
	check(q, exp);
endtask
task fr;
	@(posedge mclk) frame_end <= 1'b1;
	@(posedge mclk) frame_end <= 1'b0;
endtask
task clr;
	apb(1'b1, `REG_CTRL, 32'h1);
	apb(1'b1, `REG_CTRL, 32'h0);
endtask
task go(input logic [31:0] c);
	fr();
	apb(1'b1, `REG_CTRL, c | 32'h2);
endtask
// ==========================================================================
// scenarios
task t_regs;
	rchk(`REG_CTRL, 32'h0);
	rchk(`REG_EVENT, 32'h0);
	check(err_q, 1'b0);
	apb(1'b1, `REG_WORK_CNT, 32'h5);
	rchk(`REG_WORK_CNT, 32'h0);
	rchk(6'h38, 32'h0);
	check(err_q, 1'b1);
	rchk(6'h0e, 32'h0);
	check(err_q, 1'b1);
endtask
task t_latency;
	clr();
	apb(1'b1, `REG_LAT_CFG, 32'h0003_0001);
	go(32'h0);
	u_axi_obs_model.rd(7'd1, 32'h100, 8'd0, 3'd2, 2'd1, 6);
	u_axi_obs_model.rd(7'd1, 32'h104, 8'd0, 3'd2, 2'd1, 3);
	fr();
	u_axi_obs_model.rd(7'd2, 32'h108, 8'd0, 3'd2, 2'd1, 9);
	u_axi_obs_model.rd(7'd1, 32'h10c, 8'd0, 3'd2, 2'd1, 4);
	rchk(`REG_MAX_LAT, 32'd6);
	rchk(`REG_SAMP_NUM, 32'd2);
	rchk(`REG_ACC_SUM, 32'd10);
endtask
task t_frame;
	clr();
	apb(1'b1, `REG_LAT_CFG, 32'h1);
	go(32'h4);
	u_axi_obs_model.rd(7'd1, 32'h200, 8'd0, 3'd2, 2'd1, 5);
	repeat (20) @(posedge mclk);
	fr();
	rchk(`REG_EVENT, 32'h4);
	check(irq, 1'b1);
	apb(1'b0, `REG_WORK_CNT, 32'h0);
	check(q, 32'd30);
	u_axi_obs_model.rd(7'd1, 32'h204, 8'd0, 3'd2, 2'd1, 7);
	rchk(`REG_SAMP_NUM, 32'd1);
	rchk(`REG_ACC_SUM, 32'd5);
endtask
task t_bytes;
	clr();
	apb(1'b1, `REG_ID_CFG, 32'h1);
	go(32'h80);
	u_axi_obs_model.rd(7'd1, 32'h0, 8'd3, 3'd2, 2'd1, 1);
	u_axi_obs_model.rd(7'd2, 32'h0, 8'd7, 3'd2, 2'd1, 1);
	u_axi_obs_model.wr(7'd3, 32'h0, 8'd1, 3'd3, 2'd1);
	u_axi_obs_model.wr(7'd5, 32'h0, 8'd0, 3'd2, 2'd1);
	rchk(`REG_RD_BYTES, 32'd16);
	rchk(`REG_WR_BYTES, 32'd20);
	clr();
	apb(1'b1, `REG_ID_CFG, 32'h500);
	go(32'h158);
	u_axi_obs_model.rd(7'd2, 32'h10, 8'd0, 3'd2, 2'd1, 1);
	u_axi_obs_model.rd(7'd3, 32'h30, 8'd3, 3'd2, 2'd2, 1);
	u_axi_obs_model.wr(7'd5, 32'h3c, 8'd1, 3'd2, 2'd1);
	u_axi_obs_model.wr(7'd6, 32'h3c, 8'd1, 3'd2, 2'd1);
	rchk(`REG_RD_BYTES, 32'd80);
	rchk(`REG_WR_BYTES, 32'd128);
endtask
task t_window;
	clr();
	apb(1'b1, `REG_ID_CFG, 32'h007f_0000);
	apb(1'b1, `REG_RWIN_LOW, 32'h4000);
	apb(1'b1, `REG_RWIN_HIGH, 32'h8000);
	apb(1'b1, `REG_WWIN_LOW, 32'h4000);
	apb(1'b1, `REG_WWIN_HIGH, 32'h8000);
	go(32'h200);
	u_axi_obs_model.rd(7'd126, 32'h5000, 8'd0, 3'd2, 2'd1, 1);
	u_axi_obs_model.rd(7'd127, 32'h3ffc, 8'd0, 3'd2, 2'd1, 1);
	u_axi_obs_model.wr(7'd127, 32'h8000, 8'd0, 3'd2, 2'd1);
	repeat (3) @(posedge mclk);
	check(irq, 1'b0);
	u_axi_obs_model.rd(7'd127, 32'h4000, 8'd0, 3'd2, 2'd1, 1);
	u_axi_obs_model.wr(7'd127, 32'h7ffc, 8'd0, 3'd2, 2'd1);
	repeat (3) @(posedge mclk);
	check(irq, 1'b1);
	rchk(`REG_EVENT, 32'h007f_7f03);
	apb(1'b1, `REG_CTRL, 32'h1);
	rchk(`REG_EVENT, 32'h0);
	rchk(`REG_RD_BYTES, 32'h0);
	check(irq, 1'b0);
	apb(1'b1, `REG_CTRL, 32'h0);
	// masked low id bit lets id 127 match watch id 126
	apb(1'b1, `REG_ID_CFG, 32'h017e_0000);
	go(32'h200);
	u_axi_obs_model.rd(7'd127, 32'h5000, 8'd0, 3'd2, 2'd1, 1);
	rchk(`REG_EVENT, 32'h0000_7f01);
endtask
// ==========================================================================
// run control
task tally_and_finish;
	$display("checks %0d errors %0d", checks_done, num_errors);
	if (num_errors == 0 && checks_done > 0)
		$display("Simulation passed");
	else
		$display("Simulation failed");
	$finish;
endtask
initial begin
	{nrst, psel, penable, pwrite, frame_end, paddr, pwdata} = '0;
	repeat (4) @(posedge mclk);
	nrst <= 1'b1;
	repeat (3) @(posedge mclk);
	t_regs();
	t_latency();
	t_frame();
	t_bytes();
	t_window();
	tally_and_finish();
end
// watchdog against a hung handshake
initial begin
	repeat (20000) @(posedge mclk);
	num_errors++;
	tally_and_finish();
end
endmodule // test_bus_stat_mon
`default_nettype wire
